/* common/pcg_pkg.sv */
// Package for the clock generator controller: register map, field
// positions, reset values and timing figures.
// Assumes a 32-bit byte-addressed register port driven by the core.
package pcg_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CSR   = 32'h01b7c100;
  localparam logic [31:0] ADDR_MULT  = 32'h01b7c110;
  localparam logic [31:0] ADDR_DIV0  = 32'h01b7c114;
  localparam logic [31:0] ADDR_DIV1  = 32'h01b7c118;
  localparam logic [31:0] ADDR_DIV2  = 32'h01b7c11c;
  localparam logic [31:0] ADDR_DIV3  = 32'h01b7c120;

  // Control/status field positions
  localparam int CSR_PATH_BIT   = 0;
  localparam int CSR_PWRDN_BIT  = 1;
  localparam int CSR_RESET_BIT  = 3;
  localparam int CSR_STABLE_BIT = 6;

  // Divider register field positions
  localparam int DIV_EN_BIT     = 15;
  localparam int RATIO_W        = 5;

  // Reset values
  localparam logic       RST_PATH_SEL = 1'b0;
  localparam logic       RST_PWRDN    = 1'b0;
  localparam logic       RST_PLL_RST  = 1'b1;
  localparam logic [4:0] RST_MULT     = 5'h07;
  localparam logic [4:0] RST_DIV0     = 5'h00;
  localparam logic [4:0] RST_DIV1     = 5'h00;
  localparam logic [4:0] RST_DIV2     = 5'h01;
  localparam logic [4:0] RST_DIV3     = 5'h01;
  localparam logic       RST_DIV_EN   = 1'b1;

  // Clock-stable counter length in input clock cycles
  localparam int STABLE_CYCLES  = 4096;

endpackage

/* hdl/pcg_div.sv */
// Programmable ratio divider working on clock-enable ticks.
// Assumes src_tick comes from logic on mclk; ratio n divides by n+1.
`timescale 1ns/10ps
`default_nettype none

module pcg_div #(
  parameter int RW = 5                  // Ratio field width
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          src_tick,
  input  wire logic          enable,
  input  wire logic [RW-1:0] ratio,
  output logic               tick_q
);

  generate
    if (RW < 1) begin : g_chk
      $error("pcg_div: ratio width must be at least one");
    end
  endgenerate

  logic [RW-1:0] cnt_q;                 // Source ticks seen this period
  logic [RW-1:0] cnt_d;
  logic          tick_d;

  //////////////////////////////////////////////////////////////////////
  // Next-state: count source ticks, pulse when the count reaches ratio
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!enable) begin
      cnt_d = '0;
    end else if (src_tick) begin
      // Ratio n divides by n+1
      // Compare with >= so a smaller ratio written mid-count takes hold
      if (cnt_q >= ratio) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule

`default_nettype wire

/* hdl/pcg_ctrl.sv */
// Clock generator controller: bypass/PLL path select, prescaler,
// multiplier setting and three post-dividers producing clock ticks.
// Assumes mclk is the input reference clock; the analog PLL sits
// outside and returns its output as a one-cycle tick on mclk.
`timescale 1ns/10ps
`default_nettype none

module pcg_ctrl #(
  parameter int STABLE_CYCLES = pcg_pkg::STABLE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata_q,
  output logic             reg_rvalid_q,
  input  wire logic        pll_output_tick,
  input  wire logic        memory_clock_source,
  input  wire logic        external_memory_clock_pin,
  output logic             pll_reference_tick_q,
  output logic             pll_reset_ctl_q,
  output logic             pll_power_down_q,
  output logic [4:0]       multiplier_select_q,
  output logic             core_clock_tick_q,
  output logic             periph_bus_clock_tick_q,
  output logic             memory_if_clock_tick_q,
  output logic             periph_clock_out_pin_q
);

  localparam int SW = $clog2(STABLE_CYCLES + 1);

  generate
    if (STABLE_CYCLES < 1) begin : g_chk
      $error("pcg_ctrl: STABLE_CYCLES must be at least one");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Register state
  logic             path_sel_q, path_sel_d;       // PLL path select
  logic             pll_rst_d, pwrdn_d;
  logic [4:0]       mult_d;
  logic [4:0]       ratio_q [4];                  // Per divider ratio
  logic [4:0]       ratio_d [4];
  logic             den_q   [4];                  // Per divider enable
  logic             den_d   [4];
  logic [31:0]      rdata_d;
  logic             div_tick [4];                 // Divider outputs
  logic [31:0]      div_addr [4];

  assign div_addr[0] = pcg_pkg::ADDR_DIV0;
  assign div_addr[1] = pcg_pkg::ADDR_DIV1;
  assign div_addr[2] = pcg_pkg::ADDR_DIV2;
  assign div_addr[3] = pcg_pkg::ADDR_DIV3;

  // Stable counter state
  logic [SW-1:0]    stab_cnt_q, stab_cnt_d;
  logic             stable_q, stable_d;

  //////////////////////////////////////////////////////////////////////
  // Next register values and read mux; writes land any time
  always_comb begin
    path_sel_d = path_sel_q;
    pll_rst_d  = pll_reset_ctl_q;
    pwrdn_d    = pll_power_down_q;
    mult_d     = multiplier_select_q;
    for (int i = 0; i < 4; i++) begin
      ratio_d[i] = ratio_q[i];
      den_d[i]   = den_q[i];
    end
    rdata_d = 32'h0000_0000;              // Unmapped reads give zero
    if (reg_wr) begin
      if (reg_addr == pcg_pkg::ADDR_CSR) begin
        path_sel_d = reg_wdata[pcg_pkg::CSR_PATH_BIT];
        pwrdn_d    = reg_wdata[pcg_pkg::CSR_PWRDN_BIT];
        pll_rst_d  = reg_wdata[pcg_pkg::CSR_RESET_BIT];
      end
      if (reg_addr == pcg_pkg::ADDR_MULT) begin
        // Unsupported codes are stored as written; software avoids them
        mult_d = reg_wdata[4:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == div_addr[i]) begin
          ratio_d[i] = reg_wdata[pcg_pkg::RATIO_W-1:0];
          den_d[i]   = reg_wdata[pcg_pkg::DIV_EN_BIT];
        end
      end
    end
    if (reg_addr == pcg_pkg::ADDR_CSR) begin
      rdata_d[pcg_pkg::CSR_PATH_BIT]   = path_sel_q;
      rdata_d[pcg_pkg::CSR_PWRDN_BIT]  = pll_power_down_q;
      rdata_d[pcg_pkg::CSR_RESET_BIT]  = pll_reset_ctl_q;
      rdata_d[pcg_pkg::CSR_STABLE_BIT] = stable_q;
    end
    if (reg_addr == pcg_pkg::ADDR_MULT) begin
      rdata_d[4:0] = multiplier_select_q;
    end
    for (int i = 0; i < 4; i++) begin
      if (reg_addr == div_addr[i]) begin
        rdata_d[pcg_pkg::RATIO_W-1:0]  = ratio_q[i];
        rdata_d[pcg_pkg::DIV_EN_BIT]   = den_q[i];
      end
    end
  end

  // Register file flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      path_sel_q          <= pcg_pkg::RST_PATH_SEL;
      pll_reset_ctl_q     <= pcg_pkg::RST_PLL_RST;
      pll_power_down_q    <= pcg_pkg::RST_PWRDN;
      multiplier_select_q <= pcg_pkg::RST_MULT;
      ratio_q[0]          <= pcg_pkg::RST_DIV0;
      ratio_q[1]          <= pcg_pkg::RST_DIV1;
      ratio_q[2]          <= pcg_pkg::RST_DIV2;
      ratio_q[3]          <= pcg_pkg::RST_DIV3;
      for (int i = 0; i < 4; i++) begin
        den_q[i] <= pcg_pkg::RST_DIV_EN;
      end
      reg_rdata_q         <= 32'h0000_0000;
      reg_rvalid_q        <= 1'b0;
    end else begin
      path_sel_q          <= path_sel_d;
      pll_reset_ctl_q     <= pll_rst_d;
      pll_power_down_q    <= pwrdn_d;
      multiplier_select_q <= mult_d;
      for (int i = 0; i < 4; i++) begin
        ratio_q[i] <= ratio_d[i];
        den_q[i]   <= den_d[i];
      end
      reg_rdata_q         <= reg_rd ? rdata_d : reg_rdata_q;
      reg_rvalid_q        <= reg_rd;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Clock-stable counter; runs once after reset
  always_comb begin
    stab_cnt_d = stab_cnt_q;
    stable_d   = stable_q;
    if (!stable_q) begin
      if (stab_cnt_q == SW'(STABLE_CYCLES - 1)) begin
        stable_d = 1'b1;
      end else begin
        stab_cnt_d = stab_cnt_q + 1'b1;
      end
    end
  end

  // Stable counter flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stab_cnt_q <= '0;
      stable_q   <= 1'b0;
    end else begin
      stab_cnt_q <= stab_cnt_d;
      stable_q   <= stable_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Divider chain: prescaler on input clock, post-dividers on system ref
  logic sys_ref_tick;                   // High-frequency reference tick

  assign sys_ref_tick = path_sel_q ? pll_output_tick : 1'b1;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      // Prescaler runs on every input clock
      pcg_div #(.RW(pcg_pkg::RATIO_W)) u_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .src_tick ((g == 0) ? 1'b1 : sys_ref_tick),
        .enable   (den_q[g]),
        .ratio    (ratio_q[g]),
        .tick_q   (div_tick[g])
      );
    end
  endgenerate

  assign pll_reference_tick_q    = div_tick[0];
  assign core_clock_tick_q       = div_tick[1];
  assign periph_bus_clock_tick_q = div_tick[2];

  //////////////////////////////////////////////////////////////////////
  // External memory clock pin: two-flop sync, then rising-edge detect
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_s1_d, ext_s2_d, ext_s3_d;
  logic mem_tick_d, pin_d;

  always_comb begin
    ext_s1_d   = external_memory_clock_pin;
    ext_s2_d   = ext_s1_q;
    ext_s3_d   = ext_s2_q;
    if (memory_clock_source) begin
      mem_tick_d = ext_s2_q & ~ext_s3_q;
    end else begin
      mem_tick_d = div_tick[3];
    end
    pin_d = periph_clock_out_pin_q ^ div_tick[2];
  end

  // Sync, memory tick and pin flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q               <= 1'b0;
      ext_s2_q               <= 1'b0;
      ext_s3_q               <= 1'b0;
      memory_if_clock_tick_q <= 1'b0;
      periph_clock_out_pin_q <= 1'b0;
    end else begin
      ext_s1_q               <= ext_s1_d;
      ext_s2_q               <= ext_s2_d;
      ext_s3_q               <= ext_s3_d;
      memory_if_clock_tick_q <= mem_tick_d;
      periph_clock_out_pin_q <= pin_d;
    end
  end

endmodule

`default_nettype wire

/* bench/pcg_ctrl_props.sv */
// Port assertions for the clock generator controller.
// Assumes one mclk domain with async active-low rst_b.
`timescale 1ns/10ps
`default_nettype none
module pcg_ctrl_props (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  input wire logic        memory_clock_source,
  input wire logic        external_memory_clock_pin,
  input wire logic        pll_reset_ctl_q,
  input wire logic        pll_power_down_q,
  input wire logic [4:0]  multiplier_select_q,
  input wire logic        periph_bus_clock_tick_q,
  input wire logic        memory_if_clock_tick_q,
  input wire logic        periph_clock_out_pin_q
);
////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Control word write
  wire logic csr_wr = reg_wr && (reg_addr == pcg_pkg::ADDR_CSR);
  // Control word read and its answer
  sequence s_rd_csr;
    reg_rd && (reg_addr == pcg_pkg::ADDR_CSR) ##1 reg_rvalid_q;
  endsequence
  // Pin edge with the pin source held; covers the sync delay
  sequence s_ext_rise;
    memory_clock_source && $rose(external_memory_clock_pin)
      ##1 memory_clock_source [*3];
  endsequence
  AST_RST_BIT: assert property (
    csr_wr |=> pll_reset_ctl_q == $past(reg_wdata[3]))
    else $error("pll reset bit missed write");
  AST_PWRDN_BIT: assert property (
    csr_wr |=> pll_power_down_q == $past(reg_wdata[1]))
    else $error("power down bit missed write");
  AST_MULT_WR: assert property (
    reg_wr && reg_addr == pcg_pkg::ADDR_MULT
      |=> multiplier_select_q == $past(reg_wdata[4:0]))
    else $error("multiplier missed write");
  AST_RSV_HIGH: assert property (
    reg_rvalid_q |-> reg_rdata_q[31:16] == 16'h0000)
    else $error("upper reserved bits not zero");
  AST_RSV_CSR: assert property (
    s_rd_csr |-> reg_rdata_q[31:7] == 25'h0 && reg_rdata_q[5:4] == 2'h0
      && !reg_rdata_q[2])
    else $error("control word reserved bits not zero");
  AST_PIN_TOGGLE: assert property (
    periph_bus_clock_tick_q |-> ##[0:1] $changed(periph_clock_out_pin_q))
    else $error("clock pin missed a tick");
  AST_PIN_CAUSE: assert property (
    $changed(periph_clock_out_pin_q)
      |-> periph_bus_clock_tick_q || $past(periph_bus_clock_tick_q))
    else $error("clock pin moved without a tick");
  AST_MEM_EXT: assert property (
    s_ext_rise |-> ##[0:1] memory_if_clock_tick_q)
    else $error("memory clock missed pin edge");
  AST_MEM_QUIET: assert property (
    (memory_clock_source && !external_memory_clock_pin) [*6]
      |-> !memory_if_clock_tick_q)
    else $error("memory clock ticked without pin edge");
endmodule
bind pcg_ctrl pcg_ctrl_props i_props (.mclk(mclk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .memory_clock_source(memory_clock_source),
  .external_memory_clock_pin(external_memory_clock_pin),
  .pll_reset_ctl_q(pll_reset_ctl_q), .pll_power_down_q(pll_power_down_q),
  .multiplier_select_q(multiplier_select_q),
  .periph_bus_clock_tick_q(periph_bus_clock_tick_q),
  .memory_if_clock_tick_q(memory_if_clock_tick_q),
  .periph_clock_out_pin_q(periph_clock_out_pin_q));
`default_nettype wire

/* bench/pll_clock_generator_ctrl_tb_top.sv */
// Register-level bench for the clock generator controller.
// Inputs move at the falling edge; the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module pll_clock_generator_ctrl_tb_top;
////////////////////////////////////////////////////////////////////////
  logic        mclk = 1'b0;      // 40 MHz reference
  logic        rst_b = 1'b0;     // Held low at start
  logic        reg_wr = 1'b0;    // Write strobe
  logic        reg_rd = 1'b0;    // Read strobe
  logic [31:0] reg_addr = '0;    // Byte address
  logic [31:0] reg_wdata = '0;   // Write data
  logic        pll_tick = 1'b0;  // Stand-in for the analog loop
  logic        mem_src = 1'b0;   // External memory clock chosen
  logic        ext_pin = 1'b0;   // External memory clock pin
  logic        gen_on = 1'b0;    // Starts the loop and pin generator
  logic [7:0]  gen_cnt = 8'h00;  // Generator phase
  logic [31:0] rdata;            // Read answer
  logic        rvalid, core_t, per_t, mem_t, pin;
  logic        ref_t;            // Prescaler tick
  // Lock wait in mclk cycles: 187.5 us at 25 ns
  localparam int LOCK_CYCLES = 7500;
  int          miscompares = 0;
  int          n_tests = 0;
  pcg_ctrl #(.STABLE_CYCLES(8)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid), .pll_output_tick(pll_tick),
    .memory_clock_source(mem_src), .external_memory_clock_pin(ext_pin),
    .pll_reference_tick_q(ref_t), .pll_reset_ctl_q(),
    .pll_power_down_q(),
    .multiplier_select_q(), .core_clock_tick_q(core_t),
    .periph_bus_clock_tick_q(per_t), .memory_if_clock_tick_q(mem_t),
    .periph_clock_out_pin_q(pin));
  // Free-running reference
  always #12.5 mclk = ~mclk;
  // Loop tick every fourth cycle, pin period of eight
  always @(negedge mclk) begin
    if (gen_on) begin
      gen_cnt <= gen_cnt + 8'h01;
      pll_tick <= (gen_cnt[1:0] == 2'h3);
      ext_pin <= gen_cnt[2];
    end
  end
////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  // One-cycle write strobe, then one idle edge so that a following
  // call never raises the strobe in the step that lowered it
  // Core-side access only
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask
  // Read; answer waited for a bounded number of cycles
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    int k = 0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    while (rvalid !== 1'b1 && k < 3) begin
      @(negedge mclk);
      k++;
    end
    chk($sformatf("valid %h", a), 32'h1, {31'h0, rvalid});
    chk($sformatf("reg %h", a), e, rdata);
    @(negedge mclk);
  endtask
  // Ticks and pin edges over a 40-cycle window
  task automatic meas(input int er, input int ec, input int em,
                      input int ep);
    int r = 0;
    int c = 0;
    int m = 0;
    int p = 0;
    logic last = pin;
    repeat (40) begin
      @(negedge mclk);
      r += int'(ref_t);
      c += int'(core_t);
      m += int'(mem_t);
      p += int'(pin !== last);
      last = pin;
    end
    chk("ref ticks", er, r);
    chk("core ticks", ec, c);
    chk("memory ticks", em, m);
    chk("pin edges", ep, p);
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, about twice the lock wait plus the register tests
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    rd(pcg_pkg::ADDR_CSR, 32'h00000008);
    rd(pcg_pkg::ADDR_MULT, 32'h00000007);
    rd(pcg_pkg::ADDR_DIV0, 32'h00008000);
    rd(pcg_pkg::ADDR_DIV1, 32'h00008000);
    rd(pcg_pkg::ADDR_DIV2, 32'h00008001);
    rd(pcg_pkg::ADDR_DIV3, 32'h00008001);
    $display("test reset_values done");
    repeat (8) @(negedge mclk);
    rd(pcg_pkg::ADDR_CSR, 32'h00000048);
    $display("test stable_flag done");
    wr(pcg_pkg::ADDR_CSR, 32'hfffffffa);
    rd(pcg_pkg::ADDR_CSR, 32'h0000004a);
    wr(pcg_pkg::ADDR_CSR, 32'h00000008);
    rd(pcg_pkg::ADDR_CSR, 32'h00000048);
    wr(pcg_pkg::ADDR_MULT, 32'hffffffe4);
    rd(pcg_pkg::ADDR_MULT, 32'h00000004);
    wr(pcg_pkg::ADDR_DIV0, 32'hffffffff);
    rd(pcg_pkg::ADDR_DIV0, 32'h0000801f);
    wr(32'h01b7c104, 32'hffffffff);
    rd(32'h01b7c104, 32'h00000000);
    $display("test reserved_bits done");
    wr(pcg_pkg::ADDR_DIV0, 32'h00008003);
    wr(pcg_pkg::ADDR_DIV2, 32'h00008007);
    wr(pcg_pkg::ADDR_DIV1, 32'h00008003);
    repeat (4) @(negedge mclk);
    meas(10, 10, 20, 5);
    wr(pcg_pkg::ADDR_DIV0, 32'h00000003);
    repeat (4) @(negedge mclk);
    meas(0, 10, 20, 5);
    wr(pcg_pkg::ADDR_DIV1, 32'h00008000);
    wr(pcg_pkg::ADDR_DIV2, 32'h00008001);
    wr(pcg_pkg::ADDR_DIV0, 32'h00008000);
    $display("test bypass_dividers done");
    // Pin source chosen while the pin is idle: no memory ticks
    mem_src = 1'b1;
    wr(pcg_pkg::ADDR_DIV3, 32'h00000001);
    meas(40, 40, 0, 20);
    $display("test memory_source done");
    wr(pcg_pkg::ADDR_CSR, 32'h00000000);
    gen_on = 1'b1;
    repeat (LOCK_CYCLES) @(negedge mclk);
    wr(pcg_pkg::ADDR_CSR, 32'h00000001);
    repeat (16) @(negedge mclk);
    meas(40, 10, 5, 5);
    $display("test pll_path done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
